// file: core/ep0_ctrl_pkg.sv
package ep0_ctrl_pkg;

  // register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // byte address of the one register behind this slave
  localparam logic [ADDR_W-1:0] OUT_EP0_CONTROL_OFFSET = 12'hB00;

  // value after reset: only the endpoint active indication is set
  localparam logic [DATA_W-1:0] OUT_EP0_CONTROL_RESET = 32'h0000_8000;

  // field positions
  localparam int ENDPOINT_ENABLE_BIT = 31;
  localparam int ENDPOINT_DISABLE_BIT = 30;
  localparam int FORCE_NAK_REQUEST_BIT = 27;
  localparam int RELEASE_NAK_REQUEST_BIT = 26;
  localparam int STALL_CONTROL_BIT = 21;
  localparam int CRC_SKIP_BIT = 20;
  localparam int TRANSFER_TYPE_LSB = 18;
  localparam int NAK_STATUS_FLAG_BIT = 17;
  localparam int ENDPOINT_ACTIVE_FLAG_BIT = 15;

  // byte lanes that carry the writable fields
  localparam int LANE_TOP = 3;
  localparam int LANE_UPPER_MID = 2;

  // fixed field contents
  localparam logic [1:0] TRANSFER_TYPE_CONTROL = 2'h0;
  localparam logic ENDPOINT_ACTIVE_VALUE = 1'b1;

  // reset values of the individual state bits
  localparam logic ENDPOINT_ENABLE_RESET = 1'b0;
  localparam logic STALL_CONTROL_RESET = 1'b0;
  localparam logic NAK_STATUS_RESET = 1'b0;
  localparam logic CRC_SKIP_RESET = 1'b0;

  // axi4-lite response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // handshake chosen for a token
  typedef enum logic [1:0] {
    HS_NONE,
    HS_ACK,
    HS_NAK,
    HS_STALL
  } handshake_e;

  // events from the packet engine, all one-cycle pulses on sys_clk
  typedef struct packed {
    logic out_token;     // OUT token addressed to endpoint 0
    logic setup_token;   // SETUP token addressed to endpoint 0
    logic pkt_end;       // end of a received data packet
    logic pkt_crc_good;  // crc result, valid with pkt_end
    logic xfer_done;     // core finished the armed transfer
  } usb_event_s;

  // answer back to the packet engine, one-cycle pulses
  typedef struct packed {
    logic resp_valid;
    handshake_e resp_kind;
    logic pkt_accept;
    logic pkt_drop;
  } usb_answer_s;

  // control levels seen by the rest of the core
  typedef struct packed {
    logic endpoint_enable;
    logic stall_control;
    logic nak_status_flag;
    logic crc_skip;
  } ep_state_s;

endpackage

// file: core/set_clear_flag.sv
`timescale 1ns/1ps
module set_clear_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic flag
);

  logic flag_ff;
  logic nxt_flag;

  // set wins so an event in the clearing cycle is never lost
  always_comb begin
    nxt_flag = flag_ff;
    if (clr_pulse) begin
      nxt_flag = 1'b0;
    end
    if (set_pulse) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= RESET_VALUE;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;

endmodule // set_clear_flag

// file: core/usb_out_ep0_control.sv
// Contract
// RULE1 - enable bit 31: software sets it, only the core clears it.
// RULE2 - disable bit 30 always reads zero; writes to it do nothing.
// RULE3 - writing 1 to bit 27 sets the nak status flag.
// RULE4 - writing 1 to bit 26 clears the nak status flag.
// RULE5 - stall bit 21 set makes OUT transactions answer STALL.
// RULE6 - core clears the stall bit when a SETUP token arrives; a stall write in the same cycle wins and keeps it set.
// RULE7 - stall and nak both set: send STALL, not NAK.
// RULE8 - software keeps reserved bits 29:28 and 25:22 at reset value.
// RULE9 - after reset the register reads 0x0000_8000.
// RULE10 - nak flag set, no stall, no global nak: every OUT gets NAK.
// RULE11 - transfer type field always reads 00, control, not writable.
// RULE12 - crc skip mode set: accept OUT data without crc check.
// RULE13 - force and release nak bits are write pulses reading zero.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module usb_out_ep0_control (
  input wire logic sys_clk,
  input wire logic reset_n,
  // axi4-lite write address channel
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ep0_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data channel
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [ep0_ctrl_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [ep0_ctrl_pkg::STRB_W-1:0] s_axi_wstrb,
  // axi4-lite write response channel
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address channel
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ep0_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data channel
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [ep0_ctrl_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // packet engine side, same clock
  input wire ep0_ctrl_pkg::usb_event_s usb_event,
  input wire logic global_out_nak,
  input wire logic rx_space,
  output ep0_ctrl_pkg::usb_answer_s usb_answer,
  output ep0_ctrl_pkg::ep_state_s ep_state
);
  import ep0_ctrl_pkg::*;

  // write channel holding state
  logic aw_full_ff;
  logic nxt_aw_full;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [ADDR_W-1:0] nxt_aw_addr;
  logic w_full_ff;
  logic nxt_w_full;
  logic [DATA_W-1:0] w_data_ff;
  logic [DATA_W-1:0] nxt_w_data;
  logic [STRB_W-1:0] w_strb_ff;
  logic [STRB_W-1:0] nxt_w_strb;
  logic awready_ff;
  logic nxt_awready;
  logic wready_ff;
  logic nxt_wready;
  logic bvalid_ff;
  logic nxt_bvalid;
  logic [1:0] bresp_ff;
  logic [1:0] nxt_bresp;

  // read channel state
  logic arready_ff;
  logic nxt_arready;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [1:0] rresp_ff;
  logic [1:0] nxt_rresp;

  // decoded write strobes toward the control bits
  logic do_write;
  logic write_hit;
  logic lane_top_on;
  logic lane_mid_on;
  logic sw_set_enable;
  logic sw_set_stall;
  logic sw_force_nak;
  logic sw_release_nak;

  // control bits
  logic enable_q;
  logic stall_q;
  logic nak_q;
  logic crc_skip_ff;
  logic nxt_crc_skip;
  logic [DATA_W-1:0] readback;

  // answer path
  usb_answer_s answer_ff;
  usb_answer_s nxt_answer;

  // the write is performed once both halves are held and no response waits
  assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
  assign write_hit = (aw_addr_ff[ADDR_W-1:2] ==
                      OUT_EP0_CONTROL_OFFSET[ADDR_W-1:2]);
  assign lane_top_on = do_write && write_hit && w_strb_ff[LANE_TOP];
  assign lane_mid_on = do_write && write_hit && w_strb_ff[LANE_UPPER_MID];

  // RULE1 software sets enable
  assign sw_set_enable = lane_top_on && w_data_ff[ENDPOINT_ENABLE_BIT];
  // RULE13 only a written one acts
  assign sw_force_nak = lane_top_on && w_data_ff[FORCE_NAK_REQUEST_BIT];
  assign sw_release_nak = lane_top_on &&
                          w_data_ff[RELEASE_NAK_REQUEST_BIT];
  // writing zero to stall does nothing; only the core can clear it
  assign sw_set_stall = lane_mid_on && w_data_ff[STALL_CONTROL_BIT];

  // write channel: address and data are taken independently
  always_comb begin
    nxt_aw_full = aw_full_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_full = w_full_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_full = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_full = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_aw_full = 1'b0;
      nxt_w_full = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = write_hit ? RESP_OKAY : RESP_SLVERR;
    end
    // a held half blocks its channel, so one write at a time
    nxt_awready = !nxt_aw_full;
    nxt_wready = !nxt_w_full;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_full_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      aw_full_ff <= nxt_aw_full;
      aw_addr_ff <= nxt_aw_addr;
      w_full_ff <= nxt_w_full;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // RULE1 core clears enable
  set_clear_flag #(
    .RESET_VALUE(ENDPOINT_ENABLE_RESET)
  ) u_enable_flag (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .set_pulse(sw_set_enable),
    .clr_pulse(usb_event.xfer_done),
    .flag(enable_q)
  );

  // RULE6 setup clears stall
  set_clear_flag #(
    .RESET_VALUE(STALL_CONTROL_RESET)
  ) u_stall_flag (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .set_pulse(sw_set_stall),
    .clr_pulse(usb_event.setup_token),
    .flag(stall_q)
  );

  // RULE3 force sets nak
  // RULE4 release clears nak
  // both requests in one write: force wins, the safer answer
  set_clear_flag #(
    .RESET_VALUE(NAK_STATUS_RESET)
  ) u_nak_flag (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .set_pulse(sw_force_nak),
    .clr_pulse(sw_release_nak),
    .flag(nak_q)
  );

  // crc skip is a plain read-write bit in the upper middle lane
  always_comb begin
    nxt_crc_skip = crc_skip_ff;
    if (lane_mid_on) begin
      nxt_crc_skip = w_data_ff[CRC_SKIP_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_skip_ff <= CRC_SKIP_RESET;
    end else begin
      crc_skip_ff <= nxt_crc_skip;
    end
  end

  // read value; reserved bits are never stored, so they read zero
  always_comb begin
    readback = '0;
    readback[ENDPOINT_ENABLE_BIT] = enable_q;
    // RULE2 disable reads zero
    readback[ENDPOINT_DISABLE_BIT] = 1'b0;
    // RULE13 requests read zero
    readback[FORCE_NAK_REQUEST_BIT] = 1'b0;
    readback[RELEASE_NAK_REQUEST_BIT] = 1'b0;
    readback[STALL_CONTROL_BIT] = stall_q;
    readback[CRC_SKIP_BIT] = crc_skip_ff;
    // RULE11 type fixed control
    readback[TRANSFER_TYPE_LSB+1:TRANSFER_TYPE_LSB] =
      TRANSFER_TYPE_CONTROL;
    readback[NAK_STATUS_FLAG_BIT] = nak_q;
    // RULE9 active bit gives reset value
    readback[ENDPOINT_ACTIVE_FLAG_BIT] = ENDPOINT_ACTIVE_VALUE;
  end

  // read channel: data is captured when the address is taken
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      if (s_axi_araddr[ADDR_W-1:2] ==
          OUT_EP0_CONTROL_OFFSET[ADDR_W-1:2]) begin
        nxt_rdata = readback;
        nxt_rresp = RESP_OKAY;
      end else begin
        nxt_rdata = '0;
        nxt_rresp = RESP_SLVERR;
      end
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // handshake selection, registered so the answer lands one cycle later
  always_comb begin
    nxt_answer = '0;
    nxt_answer.resp_kind = HS_NONE;
    if (usb_event.setup_token) begin
      // setup is never refused by a device
      nxt_answer.resp_valid = 1'b1;
      nxt_answer.resp_kind = HS_ACK;
    end else if (usb_event.out_token) begin
      nxt_answer.resp_valid = 1'b1;
      if (stall_q) begin
        // RULE5 stall answers OUT
        // RULE7 stall beats nak
        nxt_answer.resp_kind = HS_STALL;
      end else if (global_out_nak || nak_q) begin
        // RULE10 nak flag answers nak
        nxt_answer.resp_kind = HS_NAK;
      end else if (!enable_q || !rx_space) begin
        // no room or not armed: ask the host to retry
        nxt_answer.resp_kind = HS_NAK;
      end else begin
        nxt_answer.resp_kind = HS_ACK;
      end
    end
    if (usb_event.pkt_end) begin
      // RULE12 crc skip accepts data
      nxt_answer.pkt_accept = usb_event.pkt_crc_good || crc_skip_ff;
      nxt_answer.pkt_drop = !(usb_event.pkt_crc_good || crc_skip_ff);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      answer_ff <= '0;
    end else begin
      answer_ff <= nxt_answer;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign usb_answer = answer_ff;
  assign ep_state = '{endpoint_enable: enable_q,
                      stall_control: stall_q,
                      nak_status_flag: nak_q,
                      crc_skip: crc_skip_ff};

endmodule // usb_out_ep0_control

// file: tb/usb_ep0_props.sv
`timescale 1ns/1ps
module usb_ep0_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ep0_ctrl_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire ep0_ctrl_pkg::usb_event_s usb_event,
  input wire logic global_out_nak,
  input wire ep0_ctrl_pkg::usb_answer_s usb_answer,
  input wire ep0_ctrl_pkg::ep_state_s ep_state
);
  import ep0_ctrl_pkg::*;
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // awready is low while an address is held, so it is low in any cycle in which a write is performed
  AST_STALL_WINS: assert property (
    usb_event.out_token && !usb_event.setup_token && ep_state.stall_control
    |=> usb_answer.resp_valid && usb_answer.resp_kind == HS_STALL)
    else $error("stall not answered");
  AST_NAK_ANSWER: assert property (
    usb_event.out_token && !usb_event.setup_token && !ep_state.stall_control
    && (ep_state.nak_status_flag || global_out_nak)
    |=> usb_answer.resp_valid && usb_answer.resp_kind == HS_NAK)
    else $error("nak not answered");
  AST_SETUP_CLEARS: assert property (
    usb_event.setup_token && s_axi_awready |=> !ep_state.stall_control)
    else $error("stall kept after setup");
  AST_CRC_SKIP: assert property (
    usb_event.pkt_end && ep_state.crc_skip && s_axi_awready
    |=> usb_answer.pkt_accept && !usb_answer.pkt_drop)
    else $error("packet dropped in skip mode");
  AST_ENABLE_CLEAR: assert property (
    $fell(ep_state.endpoint_enable) |-> $past(usb_event.xfer_done))
    else $error("enable cleared without core event");
  AST_NAK_BY_WRITE: assert property (
    $changed(ep_state.nak_status_flag) |-> !$past(s_axi_awready))
    else $error("nak flag moved without write");
  AST_FIXED_BITS: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_OKAY |-> s_axi_rdata[30] == 1'b0
    && s_axi_rdata[27:26] == 2'h0 && s_axi_rdata[19:18] == 2'h0)
    else $error("fixed bits read wrong");
  AST_READ_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_WRITE_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
endmodule // usb_ep0_props
bind usb_out_ep0_control usb_ep0_props u_usb_ep0_props (.sys_clk, .reset_n,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .usb_event, .global_out_nak,
  .usb_answer, .ep_state);

// file: tb/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
  input wire logic sys_clk,
  input wire ep0_ctrl_pkg::usb_answer_s usb_answer,
  output ep0_ctrl_pkg::usb_event_s usb_event,
  output logic global_out_nak,
  output logic rx_space
);
  import ep0_ctrl_pkg::*;
  // quiet bus, receive room available
  initial begin
    usb_event = '0;
    global_out_nak = 1'b0;
    rx_space = 1'b1;
  end
  // level controls change only just after an edge
  task automatic lines(input logic g, input logic r);
    @(posedge sys_clk);
    global_out_nak <= g;
    rx_space <= r;
  endtask
  // one-cycle event; answer stands only in the following cycle
  task automatic token(input logic [4:0] e, output usb_answer_s a);
    @(posedge sys_clk);
    usb_event <= e;
    @(posedge sys_clk);
    usb_event <= '0;
    #1;
    a = usb_answer;
  endtask
endmodule // usb_host_model

// file: tb/usb_out_ep0_control_tb.sv
`timescale 1ns/1ps
module usb_out_ep0_control_tb;
  import ep0_ctrl_pkg::*;
  localparam logic [11:0] EP0 = OUT_EP0_CONTROL_OFFSET;
  localparam logic [4:0] OUT = 5'h10, SETUP = 5'h08, BAD = 5'h04, XFER = 5'h01;
  localparam logic [4:0] ACK = 5'h14, NAK = 5'h18, STALL = 5'h1C, TOK = 5'h1C;
  logic sys_clk = 1'b0, reset_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic global_out_nak, rx_space;
  usb_event_s usb_event;
  usb_answer_s usb_answer, ans;
  ep_state_s ep_state;
  int n_errors = 0, check_count = 0;
  // protection is ignored by this slave, so it is tied
  usb_out_ep0_control u_usb_out_ep0_control (.sys_clk, .reset_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .usb_event, .global_out_nak,
    .rx_space, .usb_answer, .ep_state);
  usb_host_model u_usb_host_model (.sys_clk, .usb_answer, .usb_event,
    .global_out_nak, .rx_space);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge sys_clk);
    s_axi_awaddr <= EP0;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  // masked compare keeps token answers apart from packet verdicts
  task automatic tk(input logic [4:0] e, input logic [4:0] x,
                    input logic [4:0] m);
    u_usb_host_model.token(e, ans);
    chk("answer", 32'(x), 32'(ans & m));
  endtask
  // hang guard, far beyond the hundred or so cycles the sequence needs
  initial begin
    #300000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(EP0, 32'h0000_8000);
    rd(12'hB04, 32'h0, RESP_SLVERR);
    wr(32'hC800_0000);
    rd(EP0, 32'h8002_8000);
    tk(OUT, NAK, TOK);
    wr(32'h0400_0000);
    rd(EP0, 32'h8000_8000);
    tk(OUT, ACK, TOK);
    u_usb_host_model.lines(1'b1, 1'b1);
    tk(OUT, NAK, TOK);
    u_usb_host_model.lines(1'b0, 1'b0);
    tk(OUT, NAK, TOK);
    u_usb_host_model.lines(1'b0, 1'b1);
    wr(32'h0820_0000);
    rd(EP0, 32'h8022_8000);
    tk(OUT, STALL, TOK);
    tk(SETUP, ACK, TOK);
    rd(EP0, 32'h8002_8000);
    wr(32'h0000_0000);
    rd(EP0, 32'h8002_8000);
    tk(XFER, 5'h00, 5'h1F);
    rd(EP0, 32'h0002_8000);
    // top lane strobe off: the enable bit must not be set
    wr(32'h8000_0000, 4'h7);
    rd(EP0, 32'h0002_8000);
    wr(32'h0010_0000);
    rd(EP0, 32'h0012_8000);
    tk(BAD, 5'h02, 5'h03);
    wr(32'h0000_0000);
    tk(BAD, 5'h01, 5'h03);
    conclude();
  end
endmodule // usb_out_ep0_control_tb
